// ==== design/sfr_pkg.sv ====
// Purpose: Shared constants and helpers for the serial flash read engine link.
// Assumes: SPI mode 0 (clock idles low), MSB first, sys_clk at 250 MHz.
// Notes: Opcode values are local choices and not tied to any part.
package sfr_pkg;

    // ----------------------------------------------------------------
    // Command opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_PLAIN_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_TWO_PIN_OUTPUT_FETCH = 8'h3B;
    localparam logic [7:0] OP_SECTOR_LOCK_QUERY = 8'hE8;
    localparam logic [7:0] OP_ONE_TIME_AREA_FETCH = 8'h4B;

    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int MEM_AW = 22;
    localparam int MEM_BYTES = 4194304;
    localparam int SECT_LSB = 16;
    localparam int SECT_W = 6;
    localparam int N_SECT = 64;
    localparam int OTP_AW = 7;
    localparam int OTP_BYTES = 65;
    localparam logic [6:0] OTP_LAST = 7'h40;
    localparam int LOCK_WR_BIT = 0;
    localparam int LOCK_DN_BIT = 1;
    localparam logic LOCK_RESET = 1'h0;

    // ----------------------------------------------------------------
    // Frame bit counts
    // ----------------------------------------------------------------
    localparam logic [4:0] LAST_CMD_BIT = 5'h07;
    localparam logic [4:0] LAST_ADDR_BIT = 5'h17;
    localparam logic [4:0] LAST_DUMMY_BIT = 5'h07;
    localparam logic [2:0] LAST_SUB_ONE = 3'h7;
    localparam logic [2:0] LAST_SUB_TWO = 3'h3;
    localparam logic [5:0] TX_BITS_PLAIN = 6'h20;
    localparam logic [5:0] TX_BITS_DUMMY = 6'h28;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int SYS_PERIOD_NS = 4;
    localparam int LINK_PERIOD_NS = 160;
    localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
    localparam logic [7:0] HALF_LAST = 8'(LINK_HALF_CYC - 1);

    // ----------------------------------------------------------------
    // Opcode decode
    // ----------------------------------------------------------------
    function automatic logic op_needs_dummy(input logic [7:0] op);
        return (op == OP_FAST_READ) || (op == OP_TWO_PIN_OUTPUT_FETCH) || (op == OP_ONE_TIME_AREA_FETCH);
    endfunction : op_needs_dummy

    function automatic logic op_is_dual(input logic [7:0] op);
        return op == OP_TWO_PIN_OUTPUT_FETCH;
    endfunction : op_is_dual

    function automatic logic op_is_known(input logic [7:0] op);
        return (op == OP_PLAIN_READ) || op_needs_dummy(op) || (op == OP_SECTOR_LOCK_QUERY);
    endfunction : op_is_known

endpackage : sfr_pkg

// ==== design/sfr_link_if.sv ====
// Purpose: Four-wire link between host and flash read engine.
// Assumes: One data pin is shared; unowned pins float high.
// Notes: Pin levels are resolved here from the output enables.
`timescale 1ns/1ns
interface sfr_link_if;
    logic cs_n;
    logic sclk;
    logic host_si_o;
    logic host_si_oe;
    logic dev_si_o;
    logic dev_si_oe;
    logic dev_so_o;
    logic dev_so_oe;
    logic serial_in_pin;
    logic serial_out_pin;

    assign serial_in_pin = host_si_oe ? host_si_o : (dev_si_oe ? dev_si_o : 1'b1);
    assign serial_out_pin = dev_so_oe ? dev_so_o : 1'b1;

    modport host (output cs_n, output sclk, output host_si_o, output host_si_oe,
                  input serial_in_pin, input serial_out_pin);
    modport dev (input cs_n, input sclk, input serial_in_pin,
                 output dev_si_o, output dev_si_oe, output dev_so_o, output dev_so_oe);
endinterface : sfr_link_if

// ==== design/sfr_dev_end.sv ====
// Purpose: Device end of the flash read engine: decodes read commands and streams data.
// Assumes: Link pins sampled by sys_clk; link clock much slower than sys_clk.
// Notes: Program and erase are outside; they report through write_cycle_busy_flag.
`timescale 1ns/1ns
module sfr_dev_end import sfr_pkg::*; (
    // Clock and reset
    input logic sys_clk,
    input logic srst,
    input logic cen,
    // Link
    sfr_link_if.dev link,
    // Internal write cycle status
    input logic write_cycle_busy_flag,
    // Array preload
    input logic load_en,
    input logic load_otp,
    input logic [MEM_AW-1:0] load_addr,
    input logic [7:0] load_data,
    // Lock update
    input logic lock_wr_en,
    input logic [SECT_W-1:0] lock_wr_sector,
    input logic [1:0] lock_wr_val,
    // Program permission query
    input logic [SECT_W-1:0] query_sector,
    output logic query_permit,
    // Status
    output logic data_phase
);

    typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} sfr_dev_state_e;

    sfr_dev_state_e state_ff;
    logic [2:0] cs_sync_ff;
    logic [2:0] clk_sync_ff;
    logic [1:0] si_sync_ff;
    logic [4:0] cnt_ff;
    logic [22:0] shin_ff;
    logic [7:0] op_ff;
    logic [MEM_AW-1:0] addr_ff;
    logic [OTP_AW-1:0] otp_ptr_ff;
    logic [2:0] sub_ff;
    logic [7:0] shout_ff;
    logic so_ff;
    logic so_oe_ff;
    logic si_o_ff;
    logic si_oe_ff;
    logic permit_ff;
    logic [N_SECT-1:0] write_lock_ff;
    logic [N_SECT-1:0] lock_down_ff;
    logic [7:0] mem [0:MEM_BYTES-1];
    logic [7:0] otp_mem [0:OTP_BYTES-1];

    logic cs_n;
    logic rise;
    logic fall;
    logic si;
    logic [7:0] rx_byte;
    logic [23:0] rx_addr;
    logic [7:0] fetch_byte;
    logic [SECT_W-1:0] sect;
    logic dual;

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ----------------------------------------------------------------
    // Stage 0 of each chain is read only by stage 1.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cs_sync_ff <= 3'h7;
            clk_sync_ff <= 3'h0;
            si_sync_ff <= 2'h0;
        end else if (cen) begin
            cs_sync_ff <= {cs_sync_ff[1:0], link.cs_n};
            clk_sync_ff <= {clk_sync_ff[1:0], link.sclk};
            si_sync_ff <= {si_sync_ff[0], link.serial_in_pin};
        end
    end

    assign cs_n = cs_sync_ff[1];
    assign si = si_sync_ff[1];
    assign rise = ~cs_n & clk_sync_ff[1] & ~clk_sync_ff[2];
    assign fall = ~cs_n & ~clk_sync_ff[1] & clk_sync_ff[2];
    assign rx_byte = {shin_ff[6:0], si};
    assign rx_addr = {shin_ff, si};
    assign dual = op_is_dual(op_ff);
    assign sect = addr_ff[SECT_LSB +: SECT_W];

    // ----------------------------------------------------------------
    // Command, address and dummy capture
    // ----------------------------------------------------------------
    // Only the opcode is latched before the address completes, so an early
    // chip select rise simply drops the frame.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff <= ST_CMD;
            cnt_ff <= 5'h00;
            shin_ff <= 23'h000000;
            op_ff <= 8'h00;
        end else if (cen) begin
            if (cs_n) begin
                state_ff <= ST_CMD;
                cnt_ff <= 5'h00;
            end else if (rise) begin
                shin_ff <= {shin_ff[21:0], si};
                cnt_ff <= cnt_ff + 5'h01;
                unique case (state_ff)
                    ST_CMD: begin
                        if (cnt_ff == LAST_CMD_BIT) begin
                            op_ff <= rx_byte;
                            cnt_ff <= 5'h00;
                            if (write_cycle_busy_flag || !op_is_known(rx_byte)) begin
                                state_ff <= ST_IGNORE;
                            end else begin
                                state_ff <= ST_ADDR;
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (cnt_ff == LAST_ADDR_BIT) begin
                            cnt_ff <= 5'h00;
                            state_ff <= op_needs_dummy(op_ff) ? ST_DUMMY : ST_DATA;
                        end
                    end
                    ST_DUMMY: begin
                        if (cnt_ff == LAST_DUMMY_BIT) begin
                            cnt_ff <= 5'h00;
                            state_ff <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        cnt_ff <= 5'h00;
                    end
                    ST_IGNORE: begin
                        cnt_ff <= 5'h00;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Read pointers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            addr_ff <= '0;
            otp_ptr_ff <= '0;
        end else if (cen) begin
            if (rise && state_ff == ST_ADDR && cnt_ff == LAST_ADDR_BIT) begin
                addr_ff <= rx_addr[MEM_AW-1:0];
                otp_ptr_ff <= (rx_addr[OTP_AW-1:0] > OTP_LAST) ? OTP_LAST : rx_addr[OTP_AW-1:0];
            end else if (fall && state_ff == ST_DATA && sub_ff == 3'h0) begin
                if (op_ff == OP_ONE_TIME_AREA_FETCH) begin
                    if (otp_ptr_ff != OTP_LAST) begin
                        otp_ptr_ff <= otp_ptr_ff + 7'h01;
                    end
                end else if (op_ff != OP_SECTOR_LOCK_QUERY) begin
                    // Natural overflow of the 22-bit pointer gives the wrap
                    addr_ff <= addr_ff + 22'h000001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Byte source
    // ----------------------------------------------------------------
    always_comb begin
        if (op_ff == OP_SECTOR_LOCK_QUERY) begin
            fetch_byte = {6'h00, lock_down_ff[sect], write_lock_ff[sect]};
        end else if (op_ff == OP_ONE_TIME_AREA_FETCH) begin
            fetch_byte = otp_mem[otp_ptr_ff];
        end else begin
            fetch_byte = mem[addr_ff];
        end
    end

    // ----------------------------------------------------------------
    // Output shifter, changes only on link falling edges
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sub_ff <= 3'h0;
            shout_ff <= 8'h00;
            so_ff <= 1'b0;
            so_oe_ff <= 1'b0;
            si_o_ff <= 1'b0;
            si_oe_ff <= 1'b0;
        end else if (cen) begin
            if (cs_n || state_ff != ST_DATA) begin
                sub_ff <= 3'h0;
                so_oe_ff <= 1'b0;
                si_oe_ff <= 1'b0;
            end else if (fall) begin
                so_oe_ff <= 1'b1;
                si_oe_ff <= dual;
                sub_ff <= (sub_ff == (dual ? LAST_SUB_TWO : LAST_SUB_ONE)) ? 3'h0 : sub_ff + 3'h1;
                if (dual) begin
                    if (sub_ff == 3'h0) begin
                        so_ff <= fetch_byte[7];
                        si_o_ff <= fetch_byte[6];
                        shout_ff <= {fetch_byte[5:0], 2'b00};
                    end else begin
                        so_ff <= shout_ff[7];
                        si_o_ff <= shout_ff[6];
                        shout_ff <= {shout_ff[5:0], 2'b00};
                    end
                end else begin
                    if (sub_ff == 3'h0) begin
                        so_ff <= fetch_byte[7];
                        shout_ff <= {fetch_byte[6:0], 1'b0};
                    end else begin
                        so_ff <= shout_ff[7];
                        shout_ff <= {shout_ff[6:0], 1'b0};
                    end
                end
            end
        end
    end

    assign link.dev_so_o = so_ff;
    assign link.dev_so_oe = so_oe_ff;
    assign link.dev_si_o = si_o_ff;
    assign link.dev_si_oe = si_oe_ff;
    assign data_phase = so_oe_ff;

    // ----------------------------------------------------------------
    // Sector lock bits
    // ----------------------------------------------------------------
    // Only reset clears lock-down, standing in for power-up.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            write_lock_ff <= {N_SECT{LOCK_RESET}};
            lock_down_ff <= {N_SECT{LOCK_RESET}};
        end else if (cen) begin
            if (lock_wr_en && !lock_down_ff[lock_wr_sector]) begin
                write_lock_ff[lock_wr_sector] <= lock_wr_val[LOCK_WR_BIT];
                lock_down_ff[lock_wr_sector] <= lock_wr_val[LOCK_DN_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            permit_ff <= 1'b0;
        end else if (cen) begin
            permit_ff <= ~write_lock_ff[query_sector];
        end
    end

    assign query_permit = permit_ff;

    // ----------------------------------------------------------------
    // Storage, loaded from the user side
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (cen && load_en) begin
            if (load_otp) begin
                if (load_addr[OTP_AW-1:0] <= OTP_LAST) begin
                    otp_mem[load_addr[OTP_AW-1:0]] <= load_data;
                end
            end else begin
                mem[load_addr] <= load_data;
            end
        end
    end

endmodule : sfr_dev_end

// ==== design/sfr_host_end.sv ====
// Purpose: Host end: issues one read command per start and returns the data bytes.
// Assumes: Host makes the link clock by dividing sys_clk; mode 0.
// Notes: cmd_len of zero sends only opcode, address and any dummy byte.
`timescale 1ns/1ns
module sfr_host_end import sfr_pkg::*; (
    // Clock and reset
    input logic sys_clk,
    input logic srst,
    input logic cen,
    // Link
    sfr_link_if.host link,
    // Command
    input logic start,
    input logic [7:0] cmd_op,
    input logic [23:0] cmd_addr,
    input logic [15:0] cmd_len,
    output logic busy,
    // Returned data
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic done
);

    typedef enum logic [1:0] {HS_IDLE, HS_LEAD, HS_XFER, HS_TAIL} sfr_host_state_e;

    sfr_host_state_e state_ff;
    logic [7:0] tick_ff;
    logic sclk_ff;
    logic cs_n_ff;
    logic mosi_ff;
    logic mosi_oe_ff;
    logic [39:0] tx_ff;
    logic [5:0] tx_left_ff;
    logic [15:0] bytes_left_ff;
    logic [2:0] rx_sub_ff;
    logic [7:0] rx_sh_ff;
    logic [7:0] rx_data_ff;
    logic rx_valid_ff;
    logic done_ff;
    logic dual_ff;
    logic [1:0] so_sync_ff;
    logic [1:0] si_sync_ff;
    logic half_up;
    logic [7:0] rx_next;

    // ----------------------------------------------------------------
    // Data pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            so_sync_ff <= 2'h0;
            si_sync_ff <= 2'h0;
        end else if (cen) begin
            so_sync_ff <= {so_sync_ff[0], link.serial_out_pin};
            si_sync_ff <= {si_sync_ff[0], link.serial_in_pin};
        end
    end

    assign half_up = (tick_ff == HALF_LAST);
    // Second pin carries the lower bit of each pair
    assign rx_next = dual_ff ? {rx_sh_ff[5:0], so_sync_ff[1], si_sync_ff[1]} : {rx_sh_ff[6:0], so_sync_ff[1]};

    // ----------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff <= HS_IDLE;
            tick_ff <= 8'h00;
            sclk_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            mosi_ff <= 1'b0;
            mosi_oe_ff <= 1'b0;
            tx_ff <= 40'h0000000000;
            tx_left_ff <= 6'h00;
            bytes_left_ff <= 16'h0000;
            rx_sub_ff <= 3'h0;
            rx_sh_ff <= 8'h00;
            rx_data_ff <= 8'h00;
            rx_valid_ff <= 1'b0;
            done_ff <= 1'b0;
            dual_ff <= 1'b0;
        end else if (cen) begin
            rx_valid_ff <= 1'b0;
            done_ff <= 1'b0;
            tick_ff <= half_up ? 8'h00 : tick_ff + 8'h01;
            unique case (state_ff)
                HS_IDLE: begin
                    tick_ff <= 8'h00;
                    if (start) begin
                        cs_n_ff <= 1'b0;
                        tx_ff <= {cmd_op, cmd_addr, 8'h00};
                        mosi_ff <= cmd_op[7];
                        mosi_oe_ff <= 1'b1;
                        tx_left_ff <= op_needs_dummy(cmd_op) ? TX_BITS_DUMMY : TX_BITS_PLAIN;
                        bytes_left_ff <= cmd_len;
                        dual_ff <= op_is_dual(cmd_op);
                        rx_sub_ff <= 3'h0;
                        state_ff <= HS_LEAD;
                    end
                end
                HS_LEAD: begin
                    if (half_up) begin
                        sclk_ff <= 1'b1;
                        tx_left_ff <= tx_left_ff - 6'h01;
                        tx_ff <= {tx_ff[38:0], 1'b0};
                        state_ff <= HS_XFER;
                    end
                end
                HS_XFER: begin
                    if (half_up && sclk_ff) begin
                        sclk_ff <= 1'b0;
                        if (tx_left_ff != 6'h00) begin
                            mosi_ff <= tx_ff[39];
                        end else if (bytes_left_ff == 16'h0000) begin
                            state_ff <= HS_TAIL;
                        end else begin
                            mosi_oe_ff <= 1'b0;
                        end
                    end else if (half_up) begin
                        sclk_ff <= 1'b1;
                        if (tx_left_ff != 6'h00) begin
                            tx_left_ff <= tx_left_ff - 6'h01;
                            tx_ff <= {tx_ff[38:0], 1'b0};
                        end else begin
                            rx_sh_ff <= rx_next;
                            rx_sub_ff <= rx_sub_ff + 3'h1;
                            if (rx_sub_ff == (dual_ff ? LAST_SUB_TWO : LAST_SUB_ONE)) begin
                                rx_sub_ff <= 3'h0;
                                rx_data_ff <= rx_next;
                                rx_valid_ff <= 1'b1;
                                bytes_left_ff <= bytes_left_ff - 16'h0001;
                            end
                        end
                    end
                end
                HS_TAIL: begin
                    mosi_oe_ff <= 1'b0;
                    if (half_up && !cs_n_ff) begin
                        cs_n_ff <= 1'b1;
                        done_ff <= 1'b1;
                    end else if (half_up) begin
                        state_ff <= HS_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_ff;
    assign link.sclk = sclk_ff;
    assign link.host_si_o = mosi_ff;
    assign link.host_si_oe = mosi_oe_ff;
    assign busy = (state_ff != HS_IDLE);
    assign rx_data = rx_data_ff;
    assign rx_valid = rx_valid_ff;
    assign done = done_ff;

endmodule : sfr_host_end

// ==== dv/sfr_link_assertions.sv ====
// Purpose: Checks link pin timing between the host and device ends.
// Assumes: All link pins are in the sys_clk domain (mode 0).
// Notes: Reset disables every check.
`timescale 1ns/1ns
module sfr_link_assertions (
    // Clock and reset
    input logic sys_clk,
    input logic srst,
    // Link pins
    input logic cs_n,
    input logic sclk,
    input logic host_si_oe,
    input logic dev_si_oe,
    input logic dev_si_o,
    input logic dev_so_oe,
    input logic dev_so_o
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Opcode bit 7 is set up a full half period before the first rise
    sequence s_lead; (host_si_oe && !sclk) [*8]; endsequence
    sequence s_end; $rose(cs_n) ##1 cs_n; endsequence
    property p_lead; $fell(cs_n) |-> s_lead ##[11:15] $rose(sclk); endproperty
    a_lead: assert property (p_lead) else $error("link clock lead wrong");
    property p_end; s_end |=> cs_n; endproperty
    a_end: assert property (p_end) else $error("chip select gap short");
    property p_idle_clk; cs_n |-> !sclk; endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("clock runs outside frame");
    property p_no_fight; !(host_si_oe && dev_si_oe); endproperty
    a_no_fight: assert property (p_no_fight) else $error("both ends drive input pin");
    property p_two_pin; dev_si_oe |-> dev_so_oe; endproperty
    a_two_pin: assert property (p_two_pin) else $error("two-pin drive lacks out pin");
    property p_hold;
        dev_so_oe && $past(dev_so_oe) && sclk && $past(sclk) |-> $stable({dev_so_o, dev_si_o});
    endproperty
    a_hold: assert property (p_hold) else $error("data moved while clock high");
    property p_release; $rose(cs_n) |-> ##[0:6] (!dev_so_oe && !dev_si_oe); endproperty
    a_release: assert property (p_release) else $error("device kept driving");
    property p_quiet; cs_n [*8] |-> !dev_so_oe && !dev_si_oe && !host_si_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("pin driven while deselected");
endmodule : sfr_link_assertions

// ==== dv/serial_flash_read_engine_tb.sv ====
// Purpose: Self-checking bench joining host and device ends.
// Assumes: Both ends run on sys_clk; host divides the link clock.
// Notes: Array bytes are preloaded only at the addresses each array read command names, including frames rejected while busy.
`timescale 1ns/1ns
module serial_flash_read_engine_tb import sfr_pkg::*;;
    logic sys_clk = 0, srst = 1, start = 0, wbusy = 0, load_en = 0, load_otp = 0, lock_wr_en = 0;
    logic [7:0] cmd_op = 0, load_data = 0, rx_data;
    logic [23:0] cmd_addr = 0;
    logic [15:0] cmd_len = 0;
    logic [21:0] load_addr = 0;
    logic [5:0] lock_wr_sector = 0, query_sector = 0;
    logic [1:0] lock_wr_val = 0;
    logic busy, rx_valid, query_permit, done, data_phase;
    logic [7:0] mem [int];
    logic [7:0] otp [0:64];
    logic [1:0] lk [0:63];
    logic [7:0] ops [5] = '{OP_PLAIN_READ, OP_FAST_READ, OP_TWO_PIN_OUTPUT_FETCH, OP_SECTOR_LOCK_QUERY,
        OP_ONE_TIME_AREA_FETCH};
    int fails = 0, checks_done = 0, cyc = 0, seed = 68, i;
    sfr_link_if link ();
    sfr_host_end u_sfr_host_end (.sys_clk(sys_clk), .srst(srst), .cen(1'b1), .link(link), .start(start),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .busy(busy), .rx_data(rx_data),
        .rx_valid(rx_valid), .done(done));
    sfr_dev_end u_sfr_dev_end (.sys_clk(sys_clk), .srst(srst), .cen(1'b1), .link(link),
        .write_cycle_busy_flag(wbusy), .load_en(load_en), .load_otp(load_otp), .load_addr(load_addr),
        .load_data(load_data), .lock_wr_en(lock_wr_en), .lock_wr_sector(lock_wr_sector),
        .lock_wr_val(lock_wr_val), .query_sector(query_sector), .query_permit(query_permit),
        .data_phase(data_phase));
    sfr_link_assertions u_chk (.sys_clk(sys_clk), .srst(srst), .cs_n(link.cs_n), .sclk(link.sclk),
        .host_si_oe(link.host_si_oe), .dev_si_oe(link.dev_si_oe), .dev_si_o(link.dev_si_o),
        .dev_so_oe(link.dev_so_oe), .dev_so_o(link.dev_so_o));
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // -----------------------------------------------------------------
    // Checking and closing
    // -----------------------------------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic conclude();
        if (fails == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    // Ceiling well above the roughly 30k cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            conclude();
        end
    end
    // -----------------------------------------------------------------
    // Stimulus helpers
    // -----------------------------------------------------------------
    task automatic ld(input logic o, input logic [21:0] a, input logic [7:0] d);
        load_en = 1;
        load_otp = o;
        load_addr = a;
        load_data = d;
        if (o) otp[a[6:0]] = d;
        else mem[a] = d;
        @(posedge sys_clk) #1 load_en = 0;
        // Let an edge pass so the next load never re-raises the strobe in this step
        @(posedge sys_clk) #1;
    endtask : ld
    task automatic lkw(input logic [5:0] s, input logic [1:0] v);
        lock_wr_en = 1;
        lock_wr_sector = s;
        lock_wr_val = v;
        if (!lk[s][1]) lk[s] = v;
        @(posedge sys_clk) #1 lock_wr_en = 0;
        query_sector = s;
        repeat (2) @(posedge sys_clk);
        #1 chk(query_permit, !lk[s][0]);
    endtask : lkw
    // Rejected frames leave the pins floating high, so all ones come back
    function automatic logic [7:0] ex(input logic [7:0] op, input logic [23:0] a, input int k);
        int p;
        p = (a[6:0] + k > 64) ? 64 : a[6:0] + k;
        if (wbusy) return 8'hFF;
        if (op == OP_SECTOR_LOCK_QUERY) return {6'h00, lk[a[21:16]]};
        if (op == OP_ONE_TIME_AREA_FETCH) return otp[p];
        return mem[22'(a[21:0] + k)];
    endfunction : ex
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int n);
        int k;
        int dn;
        logic dp_seen;
        k = 0;
        dn = 0;
        dp_seen = 0;
        if (!op_is_known(op) || op == OP_SECTOR_LOCK_QUERY || op == OP_ONE_TIME_AREA_FETCH) n = n;
        else for (int t = 0; t < n; t++) ld(0, 22'(a[21:0] + t), 8'($random(seed)));
        cmd_op = op;
        cmd_addr = a;
        cmd_len = 16'(n);
        start = 1;
        @(posedge sys_clk) #1 start = 0;
        do begin
            @(posedge sys_clk) #1;
            if (rx_valid) begin
                chk(rx_data, ex(op, a, k));
                k++;
            end
            if (done) dn++;
            if (data_phase) dp_seen = 1;
        end while (busy);
        chk(k, n);
        chk(dn, 1);
        chk(dp_seen, !wbusy);
    endtask : cmd
    initial begin
        for (i = 0; i < 64; i++) lk[i] = 2'b00;
        repeat (20) @(posedge sys_clk);
        #1 srst = 0;
        for (i = 0; i < 65; i++) ld(1, 22'(i), 8'($random(seed)));
        // Top of array with junk in the ignored address bits
        for (i = 0; i < 3; i++) cmd(ops[i], {2'($random(seed)), 22'h3FFFFE}, 3);
        cmd(OP_ONE_TIME_AREA_FETCH, {17'($random(seed)), 7'h3E}, 5);
        lkw(6'h05, 2'b01);
        cmd(OP_SECTOR_LOCK_QUERY, {8'h05, 16'($random(seed))}, 2);
        lkw(6'h05, 2'b11);
        lkw(6'h05, 2'b00);
        cmd(OP_SECTOR_LOCK_QUERY, 24'h05FFFF, 1);
        lkw(6'h09, 2'b00);
        wbusy = 1;
        for (i = 0; i < 5; i++) cmd(ops[i], 24'($random(seed)), 1);
        wbusy = 0;
        for (i = 0; i < 3; i++) cmd(ops[{$random(seed)} % 5], 24'($random(seed)), 2);
        conclude();
    end
endmodule : serial_flash_read_engine_tb
